// >>> logic/avmd_detector.sv
// accelerometer vector-magnitude change detector with its byte registers
//
// Behaviour
// - event rises when distance from reference exceeds threshold past the debounce count
// - references held inside, or taken from initial-reference registers when selected
// - internal references have no register read path
// - latch off: flag follows the debounced condition, set and clear
// - latch on: flag holds until interrupt source register 0x0C is read
// - init select 0 captures current sample at enable, 1 loads init registers
// - update mode 0 replaces references with current sample on each trigger
// - update mode 1 keeps the references loaded at enable
// - init select and update mode both 1: init writes update references at once
// - enable bit starts the function, clear stops it; off after reset
// - clear mode 0 decrements debounce count per below-threshold sample
// - clear mode 1 zeroes debounce count on a below-threshold sample
// - 13-bit unsigned threshold split over high five bits and low byte
// - debounce period is count times one sample interval
// - hybrid mode halves the sample rate, so each step doubles
// - X initial reference is signed 14-bit, six upper bits in the high register
// - low byte of each initial reference holds bits seven to zero
// - Y and Z initial references follow X layout in following register pairs
`timescale 1ns/100ps
`default_nettype none

module avmd_detector (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [avmd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [avmd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [avmd_pkg::DATA_W-1:0] reg_rdata_o,
  // accelerometer samples, one valid pulse per output data sample
  input wire avmd_pkg::avmd_sample_t sample_i,
  input wire logic hybrid_mode_i,
  // event
  output logic event_flag_o
);

  // reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // replace the high or low byte of a 14-bit axis value
  function automatic avmd_pkg::avmd_axis_t put_byte(input avmd_pkg::avmd_axis_t v,
                                                    input logic hi,
                                                    input logic [7:0] d);
    avmd_pkg::avmd_axis_t r;
    r = v;
    if (hi) begin
      r[13:avmd_pkg::INIT_HI_LSB] = d[5:0];
    end else begin
      r[7:0] = d;
    end
    return r;
  endfunction : put_byte

  // register state
  avmd_pkg::avmd_cfg_t cfg_r;
  logic dbcntm_r;
  logic [avmd_pkg::THS_W-1:0] ths_r;
  logic [avmd_pkg::CNT_W-1:0] cnt_r;
  avmd_pkg::avmd_vec_t init_r;
  avmd_pkg::avmd_vec_t ref_r;
  avmd_pkg::avmd_vec_t last_r;
  logic phase_r;
  logic hit_q_r;
  logic flag_r;
  logic [avmd_pkg::DATA_W-1:0] rdata_r;

  // decode
  logic wr_cfg;
  logic wr_thi;
  logic wr_tlo;
  logic wr_cnt;
  logic wr_init;
  logic init_hi;
  logic [1:0] init_axis;
  logic en_rise;
  logic rd_src;

  always_comb begin
    wr_cfg = reg_wr_i && (reg_addr_i == avmd_pkg::OFS_CFG);
    wr_thi = reg_wr_i && (reg_addr_i == avmd_pkg::OFS_THS_HI);
    wr_tlo = reg_wr_i && (reg_addr_i == avmd_pkg::OFS_THS_LO);
    wr_cnt = reg_wr_i && (reg_addr_i == avmd_pkg::OFS_CNT);
    rd_src = reg_rd_i && (reg_addr_i == avmd_pkg::OFS_INT_SOURCE);
    en_rise = wr_cfg && reg_wdata_i[avmd_pkg::CFG_EN_BIT] && !cfg_r.en;
    // the six initial-reference registers form three high/low pairs
    wr_init = 1'b0;
    init_hi = 1'b0;
    init_axis = 2'd0;
    unique case (reg_addr_i)
      avmd_pkg::OFS_INITX_HI: begin
        wr_init = reg_wr_i;
        init_hi = 1'b1;
        init_axis = 2'd0;
      end
      avmd_pkg::OFS_INITX_LO: begin
        wr_init = reg_wr_i;
        init_axis = 2'd0;
      end
      avmd_pkg::OFS_INITY_HI: begin
        wr_init = reg_wr_i;
        init_hi = 1'b1;
        init_axis = 2'd1;
      end
      avmd_pkg::OFS_INITY_LO: begin
        wr_init = reg_wr_i;
        init_axis = 2'd1;
      end
      avmd_pkg::OFS_INITZ_HI: begin
        wr_init = reg_wr_i;
        init_hi = 1'b1;
        init_axis = 2'd2;
      end
      avmd_pkg::OFS_INITZ_LO: begin
        wr_init = reg_wr_i;
        init_axis = 2'd2;
      end
      default: begin
        wr_init = 1'b0;
      end
    endcase
  end

  // configuration register
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cfg_r <= '0;
    end else if (wr_cfg) begin
      cfg_r.ele <= reg_wdata_i[avmd_pkg::CFG_ELE_BIT];
      cfg_r.initm <= reg_wdata_i[avmd_pkg::CFG_INITM_BIT];
      cfg_r.updm <= reg_wdata_i[avmd_pkg::CFG_UPDM_BIT];
      cfg_r.en <= reg_wdata_i[avmd_pkg::CFG_EN_BIT];
    end
  end

  // threshold, clear mode and debounce count
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dbcntm_r <= 1'b0;
      ths_r <= avmd_pkg::RST_THS;
      cnt_r <= avmd_pkg::RST_BYTE;
    end else begin
      if (wr_thi) begin
        dbcntm_r <= reg_wdata_i[avmd_pkg::THS_DBCNTM_BIT];
        ths_r[12:avmd_pkg::THS_HI_LSB] <= reg_wdata_i[4:0];
      end
      if (wr_tlo) begin
        ths_r[7:0] <= reg_wdata_i;
      end
      if (wr_cnt) begin
        cnt_r <= reg_wdata_i;
      end
    end
  end

  // initial-reference registers
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      init_r <= '0;
    end else if (wr_init) begin
      unique case (init_axis)
        2'd0: init_r.x <= put_byte(init_r.x, init_hi, reg_wdata_i);
        2'd1: init_r.y <= put_byte(init_r.y, init_hi, reg_wdata_i);
        2'd2: init_r.z <= put_byte(init_r.z, init_hi, reg_wdata_i);
        default: init_r <= init_r;
      endcase
    end
  end

  // hybrid mode keeps every second sample only
  logic take;

  always_comb begin
    take = sample_i.valid && cfg_r.en && (!hybrid_mode_i || phase_r);
  end

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      phase_r <= 1'b0;
    end else if (!cfg_r.en || !hybrid_mode_i) begin
      phase_r <= 1'b0;
    end else if (sample_i.valid) begin
      phase_r <= !phase_r;
    end
  end

  // most recent sample, needed for capture at enable and on trigger
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      last_r <= '0;
    end else if (sample_i.valid) begin
      last_r <= sample_i.data;
    end
  end

  // distance test and debounce
  logic above;
  logic hit;

  avmd_dist_cmp u_dist (
    .sample_i(sample_i.data),
    .ref_i(ref_r),
    .ths_i(ths_r),
    .above_o(above)
  );

  avmd_debounce u_deb (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_r),
    .restart_i(!cfg_r.en),
    .sample_i(take),
    .above_i(above),
    .clear_mode_i(dbcntm_r),
    .limit_i(cnt_r),
    .hit_o(hit)
  );

  // trigger marks the rising edge of the debounced condition
  logic trig;

  always_comb begin
    trig = hit && !hit_q_r;
  end

  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hit_q_r <= 1'b0;
    end else begin
      hit_q_r <= hit;
    end
  end

  // references: load at enable, follow triggers or direct init writes
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ref_r <= '0;
    end else if (en_rise) begin
      // the new mode bits arrive in the same write, so use the written value
      if (reg_wdata_i[avmd_pkg::CFG_INITM_BIT]) begin
        ref_r <= init_r;
      end else begin
        ref_r <= last_r;
      end
    end else if (cfg_r.en && trig && !cfg_r.updm) begin
      ref_r <= last_r;
    end else if (cfg_r.en && cfg_r.initm && cfg_r.updm && wr_init) begin
      unique case (init_axis)
        2'd0: ref_r.x <= put_byte(init_r.x, init_hi, reg_wdata_i);
        2'd1: ref_r.y <= put_byte(init_r.y, init_hi, reg_wdata_i);
        2'd2: ref_r.z <= put_byte(init_r.z, init_hi, reg_wdata_i);
        default: ref_r <= ref_r;
      endcase
    end
    // with update mode 1 no branch above touches the references on trigger
  end

  // event flag; in latched mode a new trigger beats a clearing read
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      flag_r <= 1'b0;
    end else if (!cfg_r.ele) begin
      flag_r <= hit;
    end else if (trig) begin
      flag_r <= 1'b1;
    end else if (rd_src) begin
      flag_r <= 1'b0;
    end
  end

  // read mux; references are deliberately absent
  logic [avmd_pkg::DATA_W-1:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    unique case (reg_addr_i)
      avmd_pkg::OFS_INT_SOURCE: rd_val[avmd_pkg::INT_SRC_VECM_BIT] = flag_r;
      avmd_pkg::OFS_CFG: begin
        rd_val[avmd_pkg::CFG_ELE_BIT] = cfg_r.ele;
        rd_val[avmd_pkg::CFG_INITM_BIT] = cfg_r.initm;
        rd_val[avmd_pkg::CFG_UPDM_BIT] = cfg_r.updm;
        rd_val[avmd_pkg::CFG_EN_BIT] = cfg_r.en;
      end
      avmd_pkg::OFS_THS_HI: begin
        rd_val[avmd_pkg::THS_DBCNTM_BIT] = dbcntm_r;
        rd_val[4:0] = ths_r[12:avmd_pkg::THS_HI_LSB];
      end
      avmd_pkg::OFS_THS_LO: rd_val = ths_r[7:0];
      avmd_pkg::OFS_CNT: rd_val = cnt_r;
      avmd_pkg::OFS_INITX_HI: rd_val[5:0] = init_r.x[13:8];
      avmd_pkg::OFS_INITX_LO: rd_val = init_r.x[7:0];
      avmd_pkg::OFS_INITY_HI: rd_val[5:0] = init_r.y[13:8];
      avmd_pkg::OFS_INITY_LO: rd_val = init_r.y[7:0];
      avmd_pkg::OFS_INITZ_HI: rd_val[5:0] = init_r.z[13:8];
      avmd_pkg::OFS_INITZ_LO: rd_val = init_r.z[7:0];
      default: rd_val = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_r <= rd_val;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign event_flag_o = flag_r;

endmodule : avmd_detector

`default_nettype wire

// >>> logic/avmd_pkg.sv
// shared constants and carrier types of the vector-magnitude detector
package avmd_pkg;

  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned AXIS_W = 14;
  localparam int unsigned THS_W = 13;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SQ_W = 29;
  localparam int unsigned SUM_W = 31;

  // register offsets
  localparam logic [7:0] OFS_INT_SOURCE = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h5f;
  localparam logic [7:0] OFS_THS_HI = 8'h60;
  localparam logic [7:0] OFS_THS_LO = 8'h61;
  localparam logic [7:0] OFS_CNT = 8'h62;
  localparam logic [7:0] OFS_INITX_HI = 8'h63;
  localparam logic [7:0] OFS_INITX_LO = 8'h64;
  localparam logic [7:0] OFS_INITY_HI = 8'h65;
  localparam logic [7:0] OFS_INITY_LO = 8'h66;
  localparam logic [7:0] OFS_INITZ_HI = 8'h67;
  localparam logic [7:0] OFS_INITZ_LO = 8'h68;

  // field positions
  localparam int unsigned CFG_ELE_BIT = 6;
  localparam int unsigned CFG_INITM_BIT = 5;
  localparam int unsigned CFG_UPDM_BIT = 4;
  localparam int unsigned CFG_EN_BIT = 3;
  localparam int unsigned THS_DBCNTM_BIT = 7;
  localparam int unsigned THS_HI_LSB = 8;
  localparam int unsigned INIT_HI_LSB = 8;
  localparam int unsigned INT_SRC_VECM_BIT = 1;

  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [12:0] RST_THS = 13'h0000;
  localparam logic [13:0] RST_AXIS = 14'h0000;

  // one axis sample, signed two's complement
  typedef logic signed [AXIS_W-1:0] avmd_axis_t;

  // three-axis vector
  typedef struct packed {
    avmd_axis_t x;
    avmd_axis_t y;
    avmd_axis_t z;
  } avmd_vec_t;

  // accelerometer sample stream
  typedef struct packed {
    logic valid;
    avmd_vec_t data;
  } avmd_sample_t;

  // mode bits of the configuration register
  typedef struct packed {
    logic ele;
    logic initm;
    logic updm;
    logic en;
  } avmd_cfg_t;

endpackage : avmd_pkg

// >>> logic/avmd_dist_cmp.sv
// squared distance of a sample from the reference, compared with squared threshold
`timescale 1ns/100ps
`default_nettype none

module avmd_dist_cmp (
  // operands
  input wire avmd_pkg::avmd_vec_t sample_i,
  input wire avmd_pkg::avmd_vec_t ref_i,
  input wire logic [avmd_pkg::THS_W-1:0] ths_i,
  // result
  output logic above_o
);

  // square of one axis difference; the difference needs one bit more than the axis
  function automatic logic [avmd_pkg::SQ_W-1:0] diff_sq(input avmd_pkg::avmd_axis_t a,
                                                        input avmd_pkg::avmd_axis_t b);
    logic signed [avmd_pkg::AXIS_W:0] d;
    logic signed [2*avmd_pkg::AXIS_W+1:0] p;
    d = 15'(a) - 15'(b);
    p = d * d;
    return p[avmd_pkg::SQ_W-1:0];
  endfunction : diff_sq

  logic [avmd_pkg::SUM_W-1:0] sum;
  logic [2*avmd_pkg::THS_W-1:0] ths_sq;

  // comparing squares avoids a root; both sides are non-negative
  always_comb begin
    sum = 31'(diff_sq(sample_i.x, ref_i.x)) + 31'(diff_sq(sample_i.y, ref_i.y))
        + 31'(diff_sq(sample_i.z, ref_i.z));
    ths_sq = ths_i * ths_i;
    above_o = sum > 31'(ths_sq);
  end

endmodule : avmd_dist_cmp

`default_nettype wire

// >>> logic/avmd_debounce.sv
// sample debounce counter with saturation and two clear modes
`timescale 1ns/100ps
`default_nettype none

module avmd_debounce (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic restart_i,
  input wire logic sample_i,
  input wire logic above_i,
  input wire logic clear_mode_i,
  input wire logic [avmd_pkg::CNT_W-1:0] limit_i,
  // status
  output logic hit_o
);

  logic [avmd_pkg::CNT_W-1:0] count_r;
  logic [avmd_pkg::CNT_W-1:0] count_nxt;

  // next count per qualified sample
  always_comb begin
    if (above_i) begin
      count_nxt = (count_r < limit_i) ? count_r + 8'h01 : limit_i;
    end else if (clear_mode_i) begin
      count_nxt = 8'h00;
    end else begin
      count_nxt = (count_r != 8'h00) ? count_r - 8'h01 : 8'h00;
    end
  end

  // one count per sample interval, held clear while the function is off
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= 8'h00;
      hit_o <= 1'b0;
    end else if (restart_i) begin
      count_r <= 8'h00;
      hit_o <= 1'b0;
    end else if (sample_i) begin
      count_r <= count_nxt;
      hit_o <= above_i && (count_nxt == limit_i);
    end
  end

endmodule : avmd_debounce

`default_nettype wire

// >>> dv/avmd_detector_props.sv
// concurrent checks on the vector-magnitude detector ports
`timescale 1ns/100ps
`default_nettype none
module avmd_detector_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [avmd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [avmd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [avmd_pkg::DATA_W-1:0] reg_rdata_o,
  // samples and event
  input wire avmd_pkg::avmd_sample_t sample_i,
  input wire logic hybrid_mode_i,
  input wire logic event_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic ele_r;
  logic touch_r;
  wire logic rd_src = reg_rd_i && reg_addr_i == avmd_pkg::OFS_INT_SOURCE;
  wire logic wr_cfg = reg_wr_i && reg_addr_i == avmd_pkg::OFS_CFG;
  // shadow of the latch bit, the flag only holds while it is set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ele_r <= 1'b0;
    end else if (wr_cfg) begin
      ele_r <= reg_wdata_i[avmd_pkg::CFG_ELE_BIT];
    end
  end
  // cycles right after a clearing read or mode change are excused
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      touch_r <= 1'b0;
    end else begin
      touch_r <= rd_src || wr_cfg;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i > 8'h68 ||
      reg_addr_i < 8'h5f && reg_addr_i != 8'h0c) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");
  a_ths_readback: assert property (reg_wr_i && reg_addr_i == 8'h60 ##2
      reg_rd_i && reg_addr_i == 8'h60 |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h9f))
    else $error("threshold high byte read back wrong");
  a_src_reflects: assert property (rd_src |=> reg_rdata_o == {6'h00, $past(event_flag_o), 1'b0})
    else $error("source register does not show the flag");
  a_rise_needs_sample: assert property ($rose(event_flag_o) |-> $past(sample_i.valid, 2))
    else $error("flag rose without a sample");
  a_disable_clears: assert property (wr_cfg && reg_wdata_i[3:0] == 4'h0 &&
      !reg_wdata_i[6] |-> ##3 !event_flag_o)
    else $error("flag still set after disable");
  a_latch_hold: assert property (ele_r && event_flag_o && !rd_src && !wr_cfg &&
      !touch_r |=> event_flag_o)
    else $error("latched flag dropped without a read");
  // a trigger from the sample just before the read still wins over the clear
  a_read_clears: assert property (ele_r && rd_src && !$past(sample_i.valid) |=>
      !event_flag_o)
    else $error("latched flag not cleared by source read");
  a_reset_quiet: assert property ($rose(rst_n_i) |-> !event_flag_o [*3])
    else $error("flag set right after reset");
  c_flag_rise: cover property ($rose(event_flag_o));
  c_latched_read: cover property (ele_r && rd_src && event_flag_o);
  c_hybrid_hit: cover property (hybrid_mode_i && $rose(event_flag_o));
endmodule : avmd_detector_props
bind avmd_detector avmd_detector_props u_avmd_detector_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .sample_i(sample_i), .hybrid_mode_i(hybrid_mode_i),
  .event_flag_o(event_flag_o)
);
`default_nettype wire

// >>> dv/avmd_host_model.sv
// host software model driving the detector byte registers
`timescale 1ns/100ps
`default_nettype none
module avmd_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  // idle bus from time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // one-cycle write, then address and data scrambled so stale values help nobody
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr_reg
  // one-cycle read, data taken in the answer cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1 d = reg_rdata_i;
  endtask : rd_reg
endmodule : avmd_host_model
`default_nettype wire

// >>> dv/avmd_detector_bench.sv
// self-checking bench for the vector-magnitude detector
`timescale 1ns/100ps
`default_nettype none
module avmd_detector_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hybrid_mode_i = 1'b0;
  avmd_pkg::avmd_sample_t sample_i = '0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic reg_wr, reg_rd, event_flag;
  int error_cnt = 0;
  int checks_done = 0;
  // rows: address, write data, read-back value
  localparam logic [23:0] ROWS [13] = '{24'h5fff78, 24'h60ff9f, 24'h61ffff, 24'h62ffff,
    24'h63ff3f, 24'h64a5a5, 24'h65ff3f, 24'h665a5a, 24'h67ff3f, 24'h681111,
    24'h0cff00, 24'h40ff00, 24'h69ff00};
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  avmd_host_model u_avmd_host_model (.clk_i(clk_i), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));
  avmd_detector u_avmd_detector (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
    .sample_i(sample_i), .hybrid_mode_i(hybrid_mode_i), .event_flag_o(event_flag));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_avmd_host_model.wr_reg(a, d);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_avmd_host_model.rd_reg(a, rd_val);
    chk(rd_val, exp);
  endtask : rchk
  // one sample far apart from the next, then the settled flag
  task automatic smp(input logic [13:0] x, input logic [13:0] z, input logic exp);
    @(posedge clk_i);
    sample_i <= {1'b1, x, 14'h0000, z};
    @(posedge clk_i);
    sample_i <= {1'b0, ~x, 14'h3fff, ~z};
    repeat (3) @(posedge clk_i);
    #1 chk({7'h00, event_flag}, {7'h00, exp});
  endtask : smp
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (ROWS[i]) begin
      rchk(ROWS[i][23:16], 8'h00);
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rchk(ROWS[i][23:16], ROWS[i][7:0]);
    end
    $display("register table done");
    // fixed references of zero, threshold 10, debounce 2
    for (int a = 8'h63; a <= 8'h68; a++) wr(8'(a), 8'h00);
    wr(8'h60, 8'h00);
    wr(8'h61, 8'h0a);
    wr(8'h62, 8'h02);
    wr(8'h5f, 8'h38);
    smp(14'd11, 14'd0, 1'b0);
    smp(14'd11, 14'd0, 1'b1);
    smp(14'd10, 14'd0, 1'b0);
    smp(14'd11, 14'd0, 1'b1);
    wr(8'h60, 8'h80);
    smp(14'd0, 14'd0, 1'b0);
    smp(14'd11, 14'd0, 1'b0);
    smp(14'd11, 14'd0, 1'b1);
    // live reference writes, negative z reference
    wr(8'h62, 8'h00);
    wr(8'h61, 8'h03);
    wr(8'h64, 8'h0b);
    wr(8'h67, 8'h3f);
    wr(8'h68, 8'hfb);
    smp(14'd11, 14'h3ffb, 1'b0);
    smp(14'd11, 14'd0, 1'b1);
    $display("debounce and init reference tests done");
    // captured reference, update on trigger or kept
    for (int u = 0; u < 2; u++) begin
      wr(8'h5f, 8'h00);
      smp(14'd100, 14'd0, 1'b0);
      wr(8'h5f, u ? 8'h18 : 8'h08);
      smp(14'd200, 14'd0, 1'b1);
      smp(14'd200, 14'd0, u[0]);
    end
    $display("reference update tests done");
    // latched flag held until the source register is read
    wr(8'h5f, 8'h00);
    wr(8'h5f, 8'h58);
    smp(14'd300, 14'd0, 1'b1);
    smp(14'd200, 14'd0, 1'b1);
    rchk(8'h0c, 8'h01 << avmd_pkg::INT_SRC_VECM_BIT);
    repeat (2) @(posedge clk_i);
    #1 chk({7'h00, event_flag}, 8'h00);
    rchk(8'h0c, 8'h00);
    $display("latch test done");
    // hybrid mode uses every second sample
    wr(8'h5f, 8'h00);
    hybrid_mode_i <= 1'b1;
    wr(8'h5f, 8'h18);
    smp(14'd300, 14'd0, 1'b0);
    smp(14'd300, 14'd0, 1'b1);
    wr(8'h5f, 8'h00);
    repeat (3) @(posedge clk_i);
    #1 chk({7'h00, event_flag}, 8'h00);
    $display("hybrid and disable test done");
    // reset in mid-run with the flag up drops flag and configuration
    @(posedge clk_i);
    hybrid_mode_i <= 1'b0;
    wr(8'h5f, 8'h18);
    smp(14'd0, 14'd0, 1'b1);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk({7'h00, event_flag}, 8'h00);
    repeat (3) @(posedge clk_i);
    rchk(8'h5f, 8'h00);
    rchk(8'h0c, 8'h00);
    $display("mid-run reset test done");
    summarize();
  end
  // tests take well under 2000 cycles, so this only fires on a hang
  initial begin
    #75000;
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule : avmd_detector_bench
`default_nettype wire
